// *** rtl/adc_if_pkg.sv ***
package adc_if_pkg;

  // Sample path sizing
  localparam int SAMPLE_W    = 16;
  localparam int LATENCY     = 7;
  localparam int FIFO_DEPTH  = 8;
  localparam int PAIR_CNT    = 8;

  // Serial frame: one direction bit, seven address bits, eight data bits
  localparam int FRAME_BITS  = 16;
  localparam int HDR_BITS    = 8;
  localparam logic [4:0] CNT_HDR   = 5'h08;
  localparam logic [4:0] CNT_FRAME = 5'h10;

  // Mode register addresses
  localparam logic [6:0] REG_FRONT_ADDR  = 7'h01;
  localparam logic [6:0] REG_OUTPUT_ADDR = 7'h02;

  // Field positions in the front register
  localparam int FLD_RANDOMIZE = 0;
  localparam int FLD_GAIN      = 1;
  // Field positions in the output register
  localparam int FLD_LVDS      = 0;
  localparam int FLD_DRIVE_HI  = 1;
  localparam int FLD_TERM      = 2;
  localparam int FLD_CLK_DELAY = 3;

  // Values after reset
  localparam logic [7:0] FRONT_RST  = 8'h00;
  localparam logic [7:0] OUTPUT_RST = 8'h03;

  // Cycles after reset release before the strap level is caught
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Positions inside the synchronised pin bundle
  localparam int PIN_ENC_POS = 0;
  localparam int PIN_ENC_NEG = 1;
  localparam int PIN_SCK     = 2;
  localparam int PIN_SDI     = 3;
  localparam int PIN_CS_N    = 4;
  localparam int PIN_STRAP   = 5;
  localparam int PIN_PDN     = 6;
  localparam int PIN_W       = 7;

  // One converted sample with its range flag
  typedef struct packed {
    logic                range;
    logic [SAMPLE_W-1:0] data;
  } sample_t;

  // Operating modes in force
  typedef struct packed {
    logic randomize;
    logic gain;
    logic lvds;
    logic drive_hi;
    logic term;
    logic clk_delay;
  } mode_cfg_t;

endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/100ps
// Two flip-flop synchroniser for a bundle of pin levels
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_ff;  // First stage, read only by the second

  // Two stages; nothing but the second stage reads the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff   <= '0;
      level_out <= '0;
    end else begin
      meta_ff   <= pin_in;
      level_out <= meta_ff;
    end
  end

endmodule

// *** rtl/sample_fifo.sv ***
`timescale 1ns/100ps
// Show-ahead FIFO with valid and ready on both sides
module sample_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage
  logic [AW-1:0]    wr_ff;           // Write pointer
  logic [AW-1:0]    rd_ff;           // Read pointer
  logic [AW:0]      cnt_ff;          // Fill level
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + AW'(1);
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + AW'(1);
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// *** rtl/adc_output_and_mode_interface.sv ***
`timescale 1ns/100ps
// Function
// - Serial input bits captured on clock rise
// - Readback shifted out, open drain, falling edge
// - Shifting only while chip select low
// - Strap picks serial port or static pins
// - Parallel data pin enables output randomization
// - Parallel clock pin selects gain 1.5
// - Parallel select pin picks CMOS or LVDS
// - Power-down input tri-states all data, clock and flag outputs
// - Conversion starts on rising encode edge
// - CMOS drives sixteen bits, top bit MSB
// - CMOS data changes with output clock fall
// - Register setting delays output clock phase
// - LVDS data changes on both clock edges
// - Even bits clock low, odd bits high
// - Range flag high on over/underflow, differential
// - LVDS drive level and termination programmable
// - Sample appears seven encode cycles later
module adc_output_and_mode_interface (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Encode clock pins and power-down
  input  wire logic                           encode_clock_pos,
  input  wire logic                           encode_clock_neg,
  input  wire logic                           power_down_input,
  // Programming pins
  input  wire logic                           programming_mode_strap,
  input  wire logic                           cfg_cs_n,
  input  wire logic                           cfg_sck,
  input  wire logic                           cfg_sdi,
  output logic                                cfg_sdo_out,
  output logic                                cfg_sdo_oe,
  // Analog core result, held stable around each encode edge
  input  wire logic [adc_if_pkg::SAMPLE_W-1:0] core_sample,
  input  wire logic                           core_out_of_range,
  // Front-end and driver controls
  output logic                                front_end_gain_select,
  output logic                                lvds_drive_high,
  output logic                                lvds_term_en,
  output logic                                lvds_mode,
  // CMOS data outputs
  output logic [adc_if_pkg::SAMPLE_W-1:0]     sample_bits,
  // LVDS data pairs
  output logic [adc_if_pkg::PAIR_CNT-1:0]     ddr_bit_pair_pos,
  output logic [adc_if_pkg::PAIR_CNT-1:0]     ddr_bit_pair_neg,
  // Output clock and range flag
  output logic                                output_clock_pos,
  output logic                                output_clock_neg,
  output logic                                range_flag_pos,
  output logic                                range_flag_neg,
  // Output enable of all data, clock and flag pins
  output logic                                outputs_oe
);

  // Synchronised pins
  logic [adc_if_pkg::PIN_W-1:0] pin_s;
  logic enc_lvl;        // Encode high phase
  logic enc_prev_ff;    // Last encode level
  logic enc_rise;       // Conversion start
  logic enc_fall;       // Second half of encode cycle
  logic sck_prev_ff;    // Last serial clock level
  logic sck_rise;
  logic sck_fall;
  logic cs_n_s;
  logic pdn_s;

  // Strap capture
  logic [1:0] strap_cnt_ff;   // Wait after reset release
  logic       par_ff;         // Parallel programming mode
  logic       strap_done_ff;

  // Serial port
  logic [4:0]  spi_cnt_ff;    // Bits received in this frame
  logic [14:0] spi_rx_ff;     // Bits received so far
  logic [7:0]  spi_tx_ff;     // Readback shifter
  logic        spi_rd_ff;     // Frame is a readback
  logic [7:0]  front_reg_ff;  // Front register
  logic [7:0]  output_reg_ff; // Output register
  logic [7:0]  rd_data;       // Readback mux

  // Mode selection
  adc_if_pkg::mode_cfg_t cfg;

  // Sample pipeline
  adc_if_pkg::sample_t pipe_ff [adc_if_pkg::LATENCY];
  logic [adc_if_pkg::LATENCY-1:0] pipe_vld_ff;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                pop;
  logic                pop_armed_ff;  // One word allowed per encode cycle
  adc_if_pkg::sample_t fifo_out;
  logic [adc_if_pkg::SAMPLE_W-1:0] word;  // After randomizer
  logic [adc_if_pkg::PAIR_CNT-1:0] odd_ff;  // Odd bits held for second half
  logic                clk_phase_ff;  // Undelayed output clock
  // A late clock reuses the phase flop, which lags its next value by one cycle

  pin_sync #(
    .WIDTH (adc_if_pkg::PIN_W)
  ) u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({power_down_input, programming_mode_strap, cfg_cs_n,
                 cfg_sdi, cfg_sck, encode_clock_neg, encode_clock_pos}),
    .level_out (pin_s)
  );

  assign enc_lvl  = pin_s[adc_if_pkg::PIN_ENC_POS] & ~pin_s[adc_if_pkg::PIN_ENC_NEG];
  assign enc_rise = enc_lvl & ~enc_prev_ff;
  assign enc_fall = ~enc_lvl & enc_prev_ff;
  assign sck_rise = pin_s[adc_if_pkg::PIN_SCK] & ~sck_prev_ff;
  assign sck_fall = ~pin_s[adc_if_pkg::PIN_SCK] & sck_prev_ff;
  assign cs_n_s   = pin_s[adc_if_pkg::PIN_CS_N];
  assign pdn_s    = pin_s[adc_if_pkg::PIN_PDN];

  // Edge history of the sampled clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_prev_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
    end else begin
      enc_prev_ff <= enc_lvl;
      sck_prev_ff <= pin_s[adc_if_pkg::PIN_SCK];
    end
  end

  // strap caught once after reset; it is tied to a rail, never toggled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_ff  <= 2'h0;
      strap_done_ff <= 1'b0;
      par_ff        <= 1'b0;
    end else if (!strap_done_ff) begin
      if (strap_cnt_ff == adc_if_pkg::STRAP_WAIT) begin
        par_ff        <= pin_s[adc_if_pkg::PIN_STRAP];
        strap_done_ff <= 1'b1;
      end else begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end

  // Readback source; unmapped addresses read zero
  always_comb begin
    case (spi_rx_ff[6:0])
      adc_if_pkg::REG_FRONT_ADDR:  rd_data = front_reg_ff;
      adc_if_pkg::REG_OUTPUT_ADDR: rd_data = output_reg_ff;
      default:                     rd_data = 8'h00;
    endcase
  end

  // Serial receive and register write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_cnt_ff    <= 5'h00;
      spi_rx_ff     <= 15'h0000;
      spi_rd_ff     <= 1'b0;
      front_reg_ff  <= adc_if_pkg::FRONT_RST;
      output_reg_ff <= adc_if_pkg::OUTPUT_RST;
    end else if (par_ff || cs_n_s) begin
      // chip select high ends and aborts the frame
      spi_cnt_ff <= 5'h00;
      spi_rd_ff  <= 1'b0;
    end else if (sck_rise && spi_cnt_ff != adc_if_pkg::CNT_FRAME) begin
      // bit taken on serial clock rise
      spi_rx_ff  <= {spi_rx_ff[13:0], pin_s[adc_if_pkg::PIN_SDI]};
      spi_cnt_ff <= spi_cnt_ff + 5'h01;
      if (spi_cnt_ff == 5'h00) begin
        spi_rd_ff <= pin_s[adc_if_pkg::PIN_SDI];
      end
      // Last data bit of a write frame lands in the register
      if (spi_cnt_ff == adc_if_pkg::CNT_FRAME - 5'h01 && !spi_rd_ff) begin
        // Direction bit sits at the top, address just below it
        if (spi_rx_ff[13:7] == adc_if_pkg::REG_FRONT_ADDR) begin
          front_reg_ff <= {spi_rx_ff[6:0], pin_s[adc_if_pkg::PIN_SDI]};
        end
        if (spi_rx_ff[13:7] == adc_if_pkg::REG_OUTPUT_ADDR) begin
          output_reg_ff <= {spi_rx_ff[6:0], pin_s[adc_if_pkg::PIN_SDI]};
        end
      end
    end
  end

  // readback bits leave on the falling edge; pin only pulls low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_tx_ff   <= 8'h00;
      cfg_sdo_oe  <= 1'b0;
      cfg_sdo_out <= 1'b0;
    end else if (par_ff || cs_n_s) begin
      // Released outside a frame, the pull-up holds it high
      cfg_sdo_oe <= 1'b0;
    end else if (sck_fall && spi_rd_ff && spi_cnt_ff >= adc_if_pkg::CNT_HDR) begin
      if (spi_cnt_ff == adc_if_pkg::CNT_HDR) begin
        cfg_sdo_oe <= ~rd_data[7];
        spi_tx_ff  <= {rd_data[6:0], 1'b0};
      end else if (spi_cnt_ff != adc_if_pkg::CNT_FRAME) begin
        cfg_sdo_oe <= ~spi_tx_ff[7];
        spi_tx_ff  <= {spi_tx_ff[6:0], 1'b0};
      end else begin
        cfg_sdo_oe <= 1'b0;
      end
    end
  end

  // Mode selection from registers or static pins
  always_comb begin
    if (par_ff) begin
      cfg.randomize = pin_s[adc_if_pkg::PIN_SDI];
      cfg.gain      = pin_s[adc_if_pkg::PIN_SCK];
      // select pin picks CMOS or LVDS at full drive
      cfg.lvds      = cs_n_s;
      cfg.drive_hi  = 1'b1;
      cfg.term      = 1'b0;
      cfg.clk_delay = 1'b0;
    end else begin
      cfg.randomize = front_reg_ff[adc_if_pkg::FLD_RANDOMIZE];
      cfg.gain      = front_reg_ff[adc_if_pkg::FLD_GAIN];
      cfg.lvds      = output_reg_ff[adc_if_pkg::FLD_LVDS];
      // drive level and termination from register
      cfg.drive_hi  = output_reg_ff[adc_if_pkg::FLD_DRIVE_HI];
      cfg.term      = output_reg_ff[adc_if_pkg::FLD_TERM];
      cfg.clk_delay = output_reg_ff[adc_if_pkg::FLD_CLK_DELAY];
    end
  end

  // Mode outputs, registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      front_end_gain_select <= 1'b0;
      lvds_drive_high       <= 1'b0;
      lvds_term_en          <= 1'b0;
      lvds_mode             <= 1'b0;
    end else begin
      front_end_gain_select <= cfg.gain;
      lvds_drive_high       <= cfg.drive_hi;
      lvds_term_en          <= cfg.term;
      lvds_mode             <= cfg.lvds;
    end
  end

  // seven-stage pipeline; stalls with the FIFO so back-pressure reaches capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_vld_ff <= '0;
      for (int i = 0; i < adc_if_pkg::LATENCY; i++) begin
        pipe_ff[i] <= '0;
      end
    end else if (enc_rise && fifo_in_ready) begin
      pipe_ff[0]     <= '{range: core_out_of_range, data: core_sample};
      pipe_vld_ff[0] <= 1'b1;
      for (int i = 1; i < adc_if_pkg::LATENCY; i++) begin
        pipe_ff[i]     <= pipe_ff[i-1];
        pipe_vld_ff[i] <= pipe_vld_ff[i-1];
      end
    end
  end

  // Oldest stage leaves on the seventh encode rise
  assign fifo_in_valid = enc_rise && pipe_vld_ff[adc_if_pkg::LATENCY-1];

  sample_fifo #(
    .WIDTH ($bits(adc_if_pkg::sample_t)),
    .DEPTH (adc_if_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (pipe_ff[adc_if_pkg::LATENCY-1]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out)
  );

  // Output stalls while powered down, so the FIFO really fills
  assign pop = fifo_out_valid && pop_armed_ff && !pdn_s;

  // Randomizer folds the LSB into all fifteen bits above it
  assign word = cfg.randomize ?
                (fifo_out.data ^ {{(adc_if_pkg::SAMPLE_W-1){fifo_out.data[0]}}, 1'b0}) :
                fifo_out.data;

  // One output word per encode cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pop_armed_ff <= 1'b0;
    end else if (enc_rise) begin
      pop_armed_ff <= 1'b1;
    end else if (pop) begin
      pop_armed_ff <= 1'b0;
    end
  end

  // Data, pairs and range flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_bits      <= '0;
      ddr_bit_pair_pos <= '0;
      ddr_bit_pair_neg <= '1;
      odd_ff           <= '0;
      range_flag_pos   <= 1'b0;
      range_flag_neg   <= 1'b1;
    end else if (pop) begin
      // all sixteen bits in parallel, top bit is MSB
      sample_bits <= word;
      for (int i = 0; i < adc_if_pkg::PAIR_CNT; i++) begin
        // even bit in the clock-low half
        ddr_bit_pair_pos[i] <= word[2*i];
        ddr_bit_pair_neg[i] <= ~word[2*i];
        odd_ff[i]           <= word[2*i+1];
      end
      // flag high on overflow or underflow, negative side inverse
      range_flag_pos <= fifo_out.range;
      range_flag_neg <= ~fifo_out.range;
    end else if (enc_fall && cfg.lvds) begin
      // second data change on the other clock edge
      ddr_bit_pair_pos <= odd_ff;
      ddr_bit_pair_neg <= ~odd_ff;
    end
  end

  // clock falls with each new word, rises mid-cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_phase_ff <= 1'b0;
    end else begin
      if (pop) begin
        clk_phase_ff <= 1'b0;
      end else if (enc_fall) begin
        clk_phase_ff <= 1'b1;
      end
    end
  end

  // optional one-cycle delay of the forwarded clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_clock_pos <= 1'b0;
      output_clock_neg <= 1'b1;
    end else begin
      // Undelayed pin tracks the phase flop's next value, delayed pin its present one
      output_clock_pos <= cfg.clk_delay ? clk_phase_ff : (pop ? 1'b0 :
                          (enc_fall ? 1'b1 : clk_phase_ff));
      output_clock_neg <= cfg.clk_delay ? ~clk_phase_ff : ~(pop ? 1'b0 :
                          (enc_fall ? 1'b1 : clk_phase_ff));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outputs_oe <= 1'b0;
    end else begin
      outputs_oe <= !pdn_s;
    end
  end

  a_shift_needs_cs: assert property (
    @(posedge clk) disable iff (!rst_n)
    (spi_cnt_ff != 5'h00 && $changed(spi_cnt_ff)) |-> $past(!cs_n_s && !par_ff))
    else $error("serial bit counted without chip select");

  a_sdo_in_frame: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(cfg_sdo_oe) |-> $past(sck_fall) && spi_rd_ff && !cs_n_s)
    else $error("readback pull-down outside a falling serial edge");

  a_par_gain_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    (par_ff && $stable(pin_s[adc_if_pkg::PIN_SCK])) |=>
    front_end_gain_select == $past(pin_s[adc_if_pkg::PIN_SCK]))
    else $error("gain does not follow clock pin in parallel mode");

  a_par_lvds_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    (par_ff && $stable(cs_n_s)) |=> lvds_mode == $past(cs_n_s) && lvds_drive_high)
    else $error("output mode does not follow select pin");

  a_pdn_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    pdn_s |=> !outputs_oe ##0 !$changed(sample_bits))
    else $error("outputs driven or changing during power-down");

  a_conv_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    (enc_rise && fifo_in_ready) |=> pipe_vld_ff[0] && pipe_ff[0].data == $past(core_sample))
    else $error("sample not captured on encode rise");

  a_clk_inverse: assert property (
    @(posedge clk) disable iff (!rst_n)
    output_clock_neg == !output_clock_pos)
    else $error("negative output clock not inverse");

  a_data_clk_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($changed(sample_bits) && !cfg.clk_delay) |-> !output_clock_pos)
    else $error("data changed while output clock high");

  a_range_pair: assert property (
    @(posedge clk) disable iff (!rst_n)
    (range_flag_neg == !range_flag_pos) && (!$changed(range_flag_pos) || $past(pop)))
    else $error("range flag pair broken or changed without a word");

endmodule

// *** verif/sample_receiver.sv ***
`timescale 1ns/100ps
// Receiving logic at the far side: rebuilds each word from the pins
module sample_receiver (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // Pins from the converter
  input  wire logic                            pins_oe,
  input  wire logic                            lvds,
  input  wire logic                            clk_pos,
  input  wire logic [adc_if_pkg::SAMPLE_W-1:0] data,
  input  wire logic [adc_if_pkg::PAIR_CNT-1:0] pair_pos,
  input  wire logic                            range_pos,
  // Last word rebuilt
  output adc_if_pkg::sample_t                  word
);
  logic [adc_if_pkg::PAIR_CNT-1:0] even_ff;  // Pair levels seen with clock low
  logic [adc_if_pkg::PAIR_CNT-1:0] odd_ff;   // Pair levels seen with clock high
  adc_if_pkg::sample_t             cmos_ff;  // Full word seen with clock high
  // pair capture: clock phase picks the half, floating pins are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      even_ff <= '0;
      odd_ff  <= '0;
      cmos_ff <= '0;
    end else if (pins_oe && clk_pos) begin
      odd_ff  <= pair_pos;
      cmos_ff <= {range_pos, data};
    end else if (pins_oe) begin
      even_ff <= pair_pos;
    end
  end
  // Interleave the halves back into one word in LVDS mode
  always_comb begin
    word = cmos_ff;
    if (lvds) begin
      for (int i = 0; i < adc_if_pkg::PAIR_CNT; i++) begin
        word.data[2*i]   = even_ff[i];
        word.data[2*i+1] = odd_ff[i];
      end
    end
  end
endmodule

// *** verif/tb_adc_output_and_mode_interface.sv ***
`timescale 1ns/100ps
// Bench: serial port, strap modes, CMOS and LVDS words, power-down
module tb_adc_output_and_mode_interface;
  logic        clk, rst_n, enc, pdn, strap, cs_n, sck, sdi, c_rng;
  logic        sdo_out, sdo_oe, gain, drv, term, lvds, ocp, ocn, rfp, rfn, oe;
  logic [15:0] core, bits;
  logic [7:0]  pp, pn, rd;
  int          failures, compares, enc_cnt, n;
  adc_if_pkg::sample_t word;
  // Readback line with the board pull-up: released reads high
  wire         sdo = sdo_oe ? 1'b0 : 1'b1;

  adc_output_and_mode_interface i_adc_output_and_mode_interface (
    .clk(clk), .rst_n(rst_n), .encode_clock_pos(enc), .encode_clock_neg(~enc),
    .power_down_input(pdn), .programming_mode_strap(strap), .cfg_cs_n(cs_n),
    .cfg_sck(sck), .cfg_sdi(sdi), .cfg_sdo_out(sdo_out), .cfg_sdo_oe(sdo_oe),
    .core_sample(core), .core_out_of_range(c_rng), .front_end_gain_select(gain),
    .lvds_drive_high(drv), .lvds_term_en(term), .lvds_mode(lvds), .sample_bits(bits),
    .ddr_bit_pair_pos(pp), .ddr_bit_pair_neg(pn), .output_clock_pos(ocp),
    .output_clock_neg(ocn), .range_flag_pos(rfp), .range_flag_neg(rfn), .outputs_oe(oe)
  );
  sample_receiver i_sample_receiver (
    .clk(clk), .rst_n(rst_n), .pins_oe(oe), .lvds(lvds), .clk_pos(ocp), .data(bits),
    .pair_pos(pp), .range_pos(rfp), .word(word)
  );

  // System clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // encode at 12.5 Msps, well inside the CMOS range; edges just after clk
  initial begin
    enc = 1'b0;
    #6;
    forever #40 enc = ~enc;
  end
  // Count encode rises to judge latency
  always @(posedge enc) enc_cnt <= enc_cnt + 1;
  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    test_done();
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Step to just after a clock edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap = s;
    tick(20);
    rst_n = 1'b1;
    tick(12);
  endtask
  // host frame: chip select held low, bit set a half period before rise
  task automatic spi(input logic [15:0] f, input int nb);
    rd = '0;
    cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < nb; i++) begin
      sdi = f[15-i];
      tick(8);
      sck = 1'b1;
      tick(8);
      if (i >= 8) rd = {rd[6:0], sdo};
      sck = 1'b0;
    end
    tick(8);
    cs_n = 1'b1;
    tick(8);
  endtask
  // Change the core result one clock after the encode fall so it is stable at the next rise
  task automatic set_word(input logic [15:0] v, input logic r);
    @(negedge enc);
    tick(1);
    core = v;
    c_rng = r;
    n = enc_cnt + 1;
  endtask
  task automatic wait_word(input logic [15:0] exp, input logic dly);
    for (int k = 0; k < 400 && bits !== exp; k++) tick(1);
    chk("latency", 16'(enc_cnt), 16'(n + 7));
    chk("clk phase", ocp, 16'(dly));
    chk("clk inverse", ocn ^ ocp, 16'h0001);
  endtask
  task automatic wait_ocp(input logic v);
    for (int k = 0; k < 20 && ocp !== v; k++) tick(1);
  endtask
  function automatic logic [7:0] half(input logic [15:0] v, input int odd);
    for (int i = 0; i < 8; i++)
      half[i] = v[2*i+odd];
  endfunction

  task automatic t_reset;
    chk("lvds", lvds, 1'b1);
    chk("drive", drv, 1'b1);
    chk("term", term, 1'b0);
    chk("gain", gain, 1'b0);
    chk("oe", oe, 1'b1);
    chk("sdo idle", sdo, 1'b1);
    chk("sdo level", sdo_out, 1'b0);
  endtask
  task automatic t_write;
    spi({1'b0, 7'h01, 8'h02}, 16);
    chk("gain", gain, 1'b1);
    spi({1'b0, 7'h02, 8'h04}, 16);
    chk("cmos", lvds, 1'b0);
    chk("drive", drv, 1'b0);
    chk("term", term, 1'b1);
  endtask
  task automatic t_read;
    spi({1'b1, 7'h01, 8'h00}, 16);
    chk("rd front", rd, 8'h02);
    spi({1'b1, 7'h02, 8'h00}, 16);
    chk("rd output", rd, 8'h04);
    spi({1'b1, 7'h05, 8'h00}, 16);
    chk("rd unmapped", rd, 8'h00);
    chk("released", sdo, 1'b1);
  endtask
  task automatic t_abort;
    spi({1'b0, 7'h01, 8'h01}, 12);
    spi({1'b1, 7'h01, 8'h00}, 16);
    chk("kept", rd, 8'h02);
    chk("gain kept", gain, 1'b1);
  endtask
  task automatic t_cmos;
    set_word(16'h1234, 1'b0);
    wait_word(16'h1234, 1'b0);
    chk("flag low", rfp, 1'b0);
    set_word(16'hA5C3, 1'b1);
    wait_word(16'hA5C3, 1'b0);
    chk("flag", rfp, 1'b1);
  endtask
  task automatic t_delay;
    spi({1'b0, 7'h02, 8'h08}, 16);
    set_word(16'h0F0F, 1'b0);
    wait_word(16'h0F0F, 1'b1);
  endtask
  task automatic t_lvds;
    spi({1'b0, 7'h02, 8'h01}, 16);
    set_word(16'h9C6B, 1'b1);
    tick(160);
    chk("word", word.data, 16'h9C6B);
    chk("flag", rfp, 1'b1);
    chk("flag inv", rfn, 1'b0);
    wait_ocp(1'b0);
    chk("even", pp, half(16'h9C6B, 0));
    chk("pair inv", pn ^ pp, 16'h00FF);
    wait_ocp(1'b1);
    chk("odd", pp, half(16'h9C6B, 1));
  endtask
  task automatic t_pdn;
    pdn = 1'b1;
    tick(8);
    chk("oe off", oe, 1'b0);
    pdn = 1'b0;
    tick(8);
    chk("oe on", oe, 1'b1);
  endtask
  task automatic t_par;
    sdi = 1'b1;
    sck = 1'b1;
    cs_n = 1'b1;
    do_reset(1'b1);
    chk("gain", gain, 1'b1);
    chk("lvds", lvds, 1'b1);
    chk("drive", drv, 1'b1);
    chk("term", term, 1'b0);
    sck = 1'b0;
    cs_n = 1'b0;
    tick(8);
    chk("gain low", gain, 1'b0);
    chk("cmos", lvds, 1'b0);
    set_word(16'h1235, 1'b0);
    wait_word(16'hEDCB, 1'b0);
    sdi = 1'b0;
    set_word(16'h5678, 1'b0);
    wait_word(16'h5678, 1'b0);
  endtask

  // Main sequence
  initial begin
    failures = 0;
    compares = 0;
    enc_cnt = 0;
    rst_n = 1'b0;
    pdn = 1'b0;
    strap = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    core = 16'h0000;
    c_rng = 1'b0;
    do_reset(1'b0);
    t_reset();
    t_write();
    t_read();
    t_abort();
    t_cmos();
    t_delay();
    t_lvds();
    t_pdn();
    t_par();
    test_done();
  end
endmodule
